// ---- core/arsr_defs.svh ----
// Constants for the result and status register group: offsets, fields, codes and reset values.
// Overview of operation
// - Calibration mode write: 0 normal, 1 offset, 2 gain; 3 reserved, not used.
// - Calibration mode reads active mode; reverts to normal after one conversion.
// - Data-available register reads 0xff without new result, 0x00-0xfe otherwise.
// - Short-detect flag bit 7 set when result magnitude within sixteen-bit threshold.
// - Near-rail flag bit 6 set when a selected input is near supply or ground.
// - Bit 5 set when power-on reset occurred since flags register last read.
// - Overrange code bits 4:3 reads 0 normally, 1 when output clamped.
// - Overrange code 2 for positive, 3 for negative modulator over-range.
// - Bits 2:0 give channel number of current result and flags.
// - Result bytes: high at 0x1a, middle at 0x1b, low at 0x1c.
// - Any write to CRC register resets the CRC; data discarded.
// - Reading CRC register returns CRC over bytes most recently sent.
// - Channel-status bit 1 reads one while scan update is pending.
// - Channel-status bit 0 reads one after not-ready or repeated result read.
// - Ready releases after low byte, or after following CRC byte when selected.
// - CRC resets on ready release unless automatic reset is disabled.
// - Short threshold high byte at 0x14, low byte at 0x15.
`ifndef ARSR_DEFS_SVH
`define ARSR_DEFS_SVH

`define ARSR_ADDR_W          7
`define ARSR_ADDR_THLD_HI    7'h14
`define ARSR_ADDR_THLD_LO    7'h15
`define ARSR_ADDR_CAL_MODE   7'h17
`define ARSR_ADDR_DATA_AVAIL 7'h18
`define ARSR_ADDR_DIAG_FLAGS 7'h19
`define ARSR_ADDR_RESULT_HI  7'h1a
`define ARSR_ADDR_RESULT_MID 7'h1b
`define ARSR_ADDR_RESULT_LO  7'h1c
`define ARSR_ADDR_CRC        7'h1d
`define ARSR_ADDR_CH_STATUS  7'h1e

`define ARSR_CAL_NORMAL      2'h0
`define ARSR_CAL_OFFSET      2'h1
`define ARSR_CAL_GAIN        2'h2
`define ARSR_CAL_RESERVED    2'h3

`define ARSR_AVAIL_YES       8'h00
`define ARSR_AVAIL_NONE      8'hff

`define ARSR_OVR_NONE        2'h0
`define ARSR_THLD_RESET      16'h0000
`define ARSR_CRC_RESET       8'h00
`define ARSR_CRC_POLY        8'h07
`define ARSR_BYTE_ZERO       8'h00
`define ARSR_RESULT_ZERO     24'h000000
`define ARSR_CH_ZERO         3'h0

`define ARSR_BIT_SHORT       7
`define ARSR_BIT_RAIL        6
`define ARSR_BIT_POR         5
`define ARSR_BIT_SCAN_PEND   1
`define ARSR_BIT_STALE       0
`define ARSR_FLD_OVR_HI      4
`define ARSR_FLD_OVR_LO      3
`define ARSR_FLD_CH_HI       2
`define ARSR_FLD_CH_LO       0

`define ARSR_SEL_NONE        3'h0
`define ARSR_SEL_HI          3'h4
`define ARSR_SEL_MID         3'h2
`define ARSR_SEL_LO          3'h1

`endif

// ---- core/arsr_pkg.sv ----
// Types shared by the result and status register group.
package arsr_pkg;

	typedef enum logic [2:0] {
		ARSR_RDY_IDLE     = 3'b001,
		ARSR_RDY_ASSERTED = 3'b010,
		ARSR_RDY_WAIT_CRC = 3'b100
	} arsr_ready_state_t;

	typedef logic [1:0] arsr_cal_mode_t;
	typedef logic [1:0] arsr_ovr_code_t;

endpackage : arsr_pkg

// ---- core/arsr_regs.sv ----
// Result, diagnostic and status registers of the converter, reached from the serial link clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "arsr_defs.svh"

module arsr_regs (
	// Core clock, reset and enable.
	input  wire logic                       clk_in,
	input  wire logic                       rst_in,
	input  wire logic                       ce_in,
	// Register access from the serial link side.
	input  wire logic                       link_clk_in,
	input  wire logic                       link_req_in,
	input  wire logic                       link_wr_in,
	input  wire logic [`ARSR_ADDR_W-1:0]    link_addr_in,
	input  wire logic [7:0]                 link_wdata_in,
	output logic                            link_busy_out,
	output logic                            link_ack_out,
	output logic [7:0]                      link_rdata_out,
	// Conversion results from the datapath.
	input  wire logic                       conv_done_in,
	input  wire logic [23:0]                conv_result_in,
	input  wire logic [2:0]                 conv_channel_in,
	input  wire arsr_pkg::arsr_ovr_code_t   conv_overrange_in,
	input  wire logic                       near_rail_in,
	input  wire logic                       scan_update_pending_in,
	// Link configuration bits held elsewhere in the device.
	input  wire logic                       ready_release_after_crc_in,
	input  wire logic                       crc_auto_reset_off_in,
	// Outputs to the converter and the ready pin.
	output arsr_pkg::arsr_cal_mode_t        cal_mode_sel_out,
	output logic                            result_ready_n_out
);
	import arsr_pkg::*;

	// Link domain request capture.
	logic                    req_tgl;
	logic                    req_wr;
	logic [`ARSR_ADDR_W-1:0] req_addr;
	logic [7:0]              req_wdata;
	logic                    resp_s1;
	logic                    resp_s2;
	logic                    resp_s3;

	// Core domain state.
	logic                    req_s1;
	logic                    req_s2;
	logic                    req_s3;
	logic                    resp_tgl;
	logic [7:0]              resp_data;
	logic [15:0]             diag_threshold;
	logic [23:0]             result;
	logic [2:0]              sampled_channel_num;
	arsr_ovr_code_t          overrange_code;
	logic                    short_detect_flag;
	logic                    near_rail_flag;
	logic                    power_up_since_read;
	logic                    short_load;
	logic [2:0]              bytes_read;
	logic                    stale_read_status;
	logic [7:0]              crc_value;
	arsr_ready_state_t       ready_state;
	arsr_ready_state_t       next_ready_state;

	// Decoded access, valid for one core cycle.
	logic                    acc;
	logic                    rd_acc;
	logic                    wr_acc;
	logic                    release_ready;
	logic [23:0]             abs_result;
	logic [7:0]              rd_byte;
	logic [7:0]              diag_flags;
	logic [7:0]              chan_status;
	logic [2:0]              result_sel;
	logic                    rd_result;
	logic                    repeat_read;

	// The link clock may stop between frames, so the request is held stable in
	// registers and only its toggle is synchronised into the core domain.
	// The edge that sees the ack high is refused too, so a host may hold its request through it.
	always_ff @(posedge link_clk_in or posedge rst_in) begin
		if (rst_in) begin
			req_tgl       <= 1'b0;
			req_wr        <= 1'b0;
			req_addr      <= '0;
			req_wdata     <= `ARSR_BYTE_ZERO;
			link_busy_out <= 1'b0;
		end else if (link_req_in && !link_busy_out && !link_ack_out) begin
			req_tgl       <= ~req_tgl;
			req_wr        <= link_wr_in;
			req_addr      <= link_addr_in;
			req_wdata     <= link_wdata_in;
			link_busy_out <= 1'b1;
		end else if (resp_s2 != resp_s3) begin
			link_busy_out <= 1'b0;
		end
	end

	always_ff @(posedge link_clk_in or posedge rst_in) begin
		if (rst_in) begin
			resp_s1 <= 1'b0;
			resp_s2 <= 1'b0;
			resp_s3 <= 1'b0;
		end else begin
			resp_s1 <= resp_tgl;
			resp_s2 <= resp_s1;
			resp_s3 <= resp_s2;
		end
	end

	// Read data is loaded in the core in the same cycle as the response toggle flips, so it is stable before the flip reaches the link side.
	always_ff @(posedge link_clk_in or posedge rst_in) begin
		if (rst_in) begin
			link_ack_out   <= 1'b0;
			link_rdata_out <= `ARSR_BYTE_ZERO;
		end else begin
			link_ack_out <= (resp_s2 != resp_s3);
			if (resp_s2 != resp_s3) begin
				link_rdata_out <= resp_data;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else if (ce_in) begin
			req_s1 <= req_tgl;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	assign acc    = ce_in && (req_s2 != req_s3);
	assign rd_acc = acc && !req_wr;
	assign wr_acc = acc && req_wr;
	assign abs_result = result[23] ? 24'(-result) : result;

	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ `ARSR_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc8_step

	// Flag and status bytes are built from their field positions so the read mux stays a plain select.
	always_comb begin
		diag_flags = `ARSR_BYTE_ZERO;
		diag_flags[`ARSR_BIT_SHORT] = short_detect_flag;
		diag_flags[`ARSR_BIT_RAIL] = near_rail_flag;
		diag_flags[`ARSR_BIT_POR] = power_up_since_read;
		diag_flags[`ARSR_FLD_OVR_HI:`ARSR_FLD_OVR_LO] = overrange_code;
		diag_flags[`ARSR_FLD_CH_HI:`ARSR_FLD_CH_LO] = sampled_channel_num;
	end

	always_comb begin
		chan_status = `ARSR_BYTE_ZERO;
		chan_status[`ARSR_BIT_SCAN_PEND] = scan_update_pending_in;
		chan_status[`ARSR_BIT_STALE] = stale_read_status;
	end

	// One-hot mark of the result byte addressed, used to spot a repeated read.
	always_comb begin
		result_sel = `ARSR_SEL_NONE;
		case (req_addr)
			`ARSR_ADDR_RESULT_HI:  result_sel = `ARSR_SEL_HI;
			`ARSR_ADDR_RESULT_MID: result_sel = `ARSR_SEL_MID;
			`ARSR_ADDR_RESULT_LO:  result_sel = `ARSR_SEL_LO;
			default:               result_sel = `ARSR_SEL_NONE;
		endcase
	end

	assign rd_result   = rd_acc && (result_sel != `ARSR_SEL_NONE);
	assign repeat_read = (bytes_read & result_sel) != `ARSR_SEL_NONE;

	// Read multiplexer; unmapped offsets read as zero.
	always_comb begin
		rd_byte = `ARSR_BYTE_ZERO;
		case (req_addr)
			`ARSR_ADDR_THLD_HI:    rd_byte = diag_threshold[15:8];
			`ARSR_ADDR_THLD_LO:    rd_byte = diag_threshold[7:0];
			`ARSR_ADDR_CAL_MODE:   rd_byte = {6'h00, cal_mode_sel_out};
			`ARSR_ADDR_DATA_AVAIL: rd_byte = (ready_state == ARSR_RDY_IDLE) ? `ARSR_AVAIL_NONE : `ARSR_AVAIL_YES;
			`ARSR_ADDR_DIAG_FLAGS: rd_byte = diag_flags;
			`ARSR_ADDR_RESULT_HI:  rd_byte = result[23:16];
			`ARSR_ADDR_RESULT_MID: rd_byte = result[15:8];
			`ARSR_ADDR_RESULT_LO:  rd_byte = result[7:0];
			`ARSR_ADDR_CRC:        rd_byte = crc_value;
			`ARSR_ADDR_CH_STATUS:  rd_byte = chan_status;
			default:               rd_byte = `ARSR_BYTE_ZERO;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			resp_tgl  <= 1'b0;
			resp_data <= `ARSR_BYTE_ZERO;
		end else if (acc) begin
			resp_tgl  <= ~resp_tgl;
			resp_data <= req_wr ? `ARSR_BYTE_ZERO : rd_byte;
		end
	end

	// Threshold registers.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			diag_threshold <= `ARSR_THLD_RESET;
		end else if (wr_acc && req_addr == `ARSR_ADDR_THLD_HI) begin
			diag_threshold[15:8] <= req_wdata;
		end else if (wr_acc && req_addr == `ARSR_ADDR_THLD_LO) begin
			diag_threshold[7:0] <= req_wdata;
		end
	end

	// A coefficient mode runs for the next conversion only; the reserved code is refused.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cal_mode_sel_out <= `ARSR_CAL_NORMAL;
		end else if (ce_in) begin
			if (wr_acc && req_addr == `ARSR_ADDR_CAL_MODE && req_wdata[1:0] != `ARSR_CAL_RESERVED) begin
				cal_mode_sel_out <= req_wdata[1:0];
			end else if (conv_done_in) begin
				cal_mode_sel_out <= `ARSR_CAL_NORMAL;
			end
		end
	end

	// Result, channel, overrange code and near-rail flag are captured in one cycle so a multi-byte read is coherent.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			result              <= `ARSR_RESULT_ZERO;
			sampled_channel_num <= `ARSR_CH_ZERO;
			overrange_code      <= `ARSR_OVR_NONE;
			near_rail_flag      <= 1'b0;
		end else if (ce_in && conv_done_in) begin
			result              <= conv_result_in;
			sampled_channel_num <= conv_channel_in;
			overrange_code      <= conv_overrange_in;
			near_rail_flag      <= near_rail_in;
		end
	end

	// The magnitude needs the stored result, so the comparison lands one cycle after capture and is
	// then held; a later threshold write leaves the flag of the held result alone.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			short_load <= 1'b0;
		end else if (ce_in) begin
			short_load <= conv_done_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			short_detect_flag <= 1'b0;
		end else if (ce_in && short_load) begin
			short_detect_flag <= (abs_result[23:8] <= diag_threshold);
		end
	end

	// Only a power-on reset sets this bit, so a read can never lose a set.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			power_up_since_read <= 1'b1;
		end else if (rd_acc && req_addr == `ARSR_ADDR_DIAG_FLAGS) begin
			power_up_since_read <= 1'b0;
		end
	end

	// Marks the result bytes that went out since the last capture; a new capture starts afresh.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			bytes_read <= `ARSR_SEL_NONE;
		end else if (ce_in && conv_done_in) begin
			bytes_read <= `ARSR_SEL_NONE;
		end else if (rd_result) begin
			bytes_read <= bytes_read | result_sel;
		end
	end

	// A result byte read counts as stale when no fresh result is held or that byte was read before.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stale_read_status <= 1'b0;
		end else if (rd_result) begin
			stale_read_status <= (ready_state == ARSR_RDY_IDLE) || repeat_read;
		end
	end

	// Ready indication; a new conversion takes priority over a release in the same cycle.
	always_comb begin
		next_ready_state = ready_state;
		release_ready    = 1'b0;
		case (ready_state)
			ARSR_RDY_IDLE: begin
				next_ready_state = ARSR_RDY_IDLE;
			end
			ARSR_RDY_ASSERTED: begin
				if (rd_acc && req_addr == `ARSR_ADDR_RESULT_LO) begin
					if (ready_release_after_crc_in) begin
						next_ready_state = ARSR_RDY_WAIT_CRC;
					end else begin
						next_ready_state = ARSR_RDY_IDLE;
						release_ready    = 1'b1;
					end
				end
			end
			ARSR_RDY_WAIT_CRC: begin
				if (rd_acc && req_addr == `ARSR_ADDR_CRC) begin
					next_ready_state = ARSR_RDY_IDLE;
					release_ready    = 1'b1;
				end
			end
			default: begin
				next_ready_state = ARSR_RDY_IDLE;
			end
		endcase
		if (ce_in && conv_done_in) begin
			next_ready_state = ARSR_RDY_ASSERTED;
			release_ready    = 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ready_state <= ARSR_RDY_IDLE;
		end else if (ce_in) begin
			ready_state <= next_ready_state;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			result_ready_n_out <= 1'b1;
		end else if (ce_in) begin
			result_ready_n_out <= (next_ready_state == ARSR_RDY_IDLE);
		end
	end

	// CRC accumulates every byte sent to the host except reads of the CRC itself;
	// a reset in the same cycle as a byte wins, so the next frame starts clean.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			crc_value <= `ARSR_CRC_RESET;
		end else if (wr_acc && req_addr == `ARSR_ADDR_CRC) begin
			crc_value <= `ARSR_CRC_RESET;
		end else if (release_ready && !crc_auto_reset_off_in) begin
			crc_value <= `ARSR_CRC_RESET;
		end else if (rd_acc && req_addr != `ARSR_ADDR_CRC) begin
			crc_value <= crc8_step(crc_value, rd_byte);
		end
	end

endmodule : arsr_regs
`default_nettype wire

// ---- tb/arsr_regs_asserts.sv ----
// Port-level checks for the result and status register group.
`timescale 1ns/1ps
`default_nettype none
module arsr_regs_asserts (
	// Clocks and reset.
	input wire logic                     clk_in,
	input wire logic                     rst_in,
	input wire logic                     link_clk_in,
	// Watched inputs.
	input wire logic                     ce_in,
	input wire logic                     conv_done_in,
	input wire logic                     link_req_in,
	input wire logic                     link_wr_in,
	input wire logic [6:0]               link_addr_in,
	input wire logic                     ready_release_after_crc_in,
	// Watched outputs.
	input wire logic                     link_busy_out,
	input wire logic                     link_ack_out,
	input wire logic [7:0]               link_rdata_out,
	input wire arsr_pkg::arsr_cal_mode_t cal_mode_sel_out,
	input wire logic                     result_ready_n_out
);
	import arsr_pkg::*;
	logic       pend_rd;
	logic [6:0] pend_addr;
	// Remembers the access in flight, so an answer can be judged by what was asked.
	always_ff @(posedge link_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pend_rd   <= 1'b0;
			pend_addr <= 7'h00;
		end else if (link_req_in && !link_busy_out && !link_ack_out) begin
			pend_rd   <= !link_wr_in;
			pend_addr <= link_addr_in;
		end
	end
	sequence s_take;
		link_req_in && !link_busy_out && !link_ack_out;
	endsequence
	sequence s_answer;
		link_busy_out[*3] ##[1:3] link_ack_out;
	endsequence
	AST_CAL_NO_RSVD: assert property (@(posedge clk_in) disable iff (rst_in) cal_mode_sel_out != 2'h3)
		else $error("calibration mode shows the reserved code");
	AST_CAL_REVERT: assert property (@(posedge clk_in) disable iff (rst_in)
		cal_mode_sel_out != 2'h0 && conv_done_in && ce_in |=> cal_mode_sel_out == 2'h0)
		else $error("calibration mode did not return to normal after a conversion");
	AST_CAPTURE_READY: assert property (@(posedge clk_in) disable iff (rst_in)
		conv_done_in && ce_in |=> !result_ready_n_out)
		else $error("ready not asserted after a conversion");
	AST_CE_FREEZE: assert property (@(posedge clk_in) disable iff (rst_in)
		!ce_in |=> $stable(result_ready_n_out) && $stable(cal_mode_sel_out))
		else $error("core state moved with the enable low");
	AST_ACCESS_ANSWER: assert property (@(posedge link_clk_in) disable iff (rst_in) s_take |=> s_answer)
		else $error("access not answered in time");
	AST_ACK_PULSE: assert property (@(posedge link_clk_in) disable iff (rst_in)
		link_ack_out |-> !link_busy_out ##1 !link_ack_out)
		else $error("ack not a single pulse with busy low");
	AST_WRITE_ZERO: assert property (@(posedge link_clk_in) disable iff (rst_in)
		link_ack_out && !pend_rd |-> link_rdata_out == 8'h00)
		else $error("write answered with nonzero data");
	AST_UNMAPPED_ZERO: assert property (@(posedge link_clk_in) disable iff (rst_in)
		link_ack_out && pend_rd && pend_addr >= 7'h20 |-> link_rdata_out == 8'h00)
		else $error("unmapped read returned data");
	AST_LOW_RELEASE: assert property (@(posedge link_clk_in) disable iff (rst_in)
		link_ack_out && pend_rd && pend_addr == 7'h1c && !ready_release_after_crc_in |-> result_ready_n_out)
		else $error("ready still asserted after the low byte read");
endmodule : arsr_regs_asserts
bind arsr_regs arsr_regs_asserts u_chk (.clk_in, .rst_in, .link_clk_in, .ce_in, .conv_done_in, .link_req_in,
	.link_wr_in, .link_addr_in, .ready_release_after_crc_in, .link_busy_out, .link_ack_out, .link_rdata_out,
	.cal_mode_sel_out, .result_ready_n_out);
`default_nettype wire

// ---- tb/arsr_host_model.sv ----
// Host side of the register link; its clock runs only while an access is in flight.
`timescale 1ns/1ps
`default_nettype none
module arsr_host_model (
	// Link pins driven by the host.
	output logic       link_clk_out,
	output logic       link_req_out,
	output logic       link_wr_out,
	output logic [6:0] link_addr_out,
	output logic [7:0] link_wdata_out,
	// Answer from the register group.
	input wire logic       link_ack_in,
	input wire logic [7:0] link_rdata_in
);
	initial begin
		link_clk_out = 1'b0;
		link_req_out = 1'b0;
		link_wr_out = 1'b0;
		link_addr_out = 7'h00;
		link_wdata_out = 8'h00;
	end
	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic ok);
		ok = 1'b0;
		q = 8'h00;
		link_req_out = 1'b1;
		link_wr_out = w;
		link_addr_out = a;
		link_wdata_out = d;
		// The answer is taken at the rising edge that sees the ack high, and only then released.
		for (int i = 0; i < 12 && !ok; i++) begin
			#62.5;
			if (link_ack_in === 1'b1) begin
				ok = 1'b1;
				q = link_rdata_in;
			end
			link_clk_out = 1'b1;
			#1;
			if (ok) begin
				link_req_out = 1'b0;
				link_addr_out = ~a;
				link_wdata_out = ~d;
			end
			#61.5 link_clk_out = 1'b0;
		end
		link_req_out = 1'b0;
		#62.5 link_clk_out = 1'b1;
		#62.5 link_clk_out = 1'b0;
	endtask : xfer
endmodule : arsr_host_model
`default_nettype wire

// ---- tb/arsr_regs_tb_top.sv ----
// Self-checking bench for the result and status register group.
`timescale 1ns/1ps
`default_nettype none
module arsr_regs_tb_top;
	import arsr_pkg::*;
	logic           clk, rst, ce, cdone, rail, scanp, rel_crc, crc_off, lclk, lreq, lwr, busy, ack, ready_n;
	logic [23:0]    res;
	logic [2:0]     ch;
	arsr_ovr_code_t ovr;
	arsr_cal_mode_t cal;
	logic [6:0]     laddr;
	logic [7:0]     lwd, lrd, exp_crc;
	int             n_mismatch, checks_done;

	arsr_regs dut (.clk_in(clk), .rst_in(rst), .ce_in(ce), .link_clk_in(lclk), .link_req_in(lreq),
		.link_wr_in(lwr), .link_addr_in(laddr), .link_wdata_in(lwd), .link_busy_out(busy), .link_ack_out(ack),
		.link_rdata_out(lrd), .conv_done_in(cdone), .conv_result_in(res), .conv_channel_in(ch),
		.conv_overrange_in(ovr), .near_rail_in(rail), .scan_update_pending_in(scanp),
		.ready_release_after_crc_in(rel_crc), .crc_auto_reset_off_in(crc_off), .cal_mode_sel_out(cal),
		.result_ready_n_out(ready_n));
	arsr_host_model host (.link_clk_out(lclk), .link_req_out(lreq), .link_wr_out(lwr), .link_addr_out(laddr),
		.link_wdata_out(lwd), .link_ack_in(ack), .link_rdata_in(lrd));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic close_out();
		$display("Counts: %0d mismatches, %0d checks", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		repeat (8) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
		return r;
	endfunction : crc_step
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g, input logic [7:0] m = 8'hff);
		checks_done++;
		if ((g & m) !== (e & m)) begin
			$display("ERROR %s expected %h seen %h", what, e & m, g & m);
			n_mismatch++;
		end
	endtask : chk
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		logic ok;
		host.xfer(w, a, d, q, ok);
		if (ok !== 1'b1) begin
			$display("ERROR link ack expected 1 seen %b", ok);
			n_mismatch++;
			close_out();
		end
	endtask : acc
	// The expected check value follows every byte read except the check value itself.
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, q);
		chk($sformatf("reg %h", a), e, q, m);
		if (a != 7'h1d)
			exp_crc = crc_step(exp_crc, e);
	endtask : rd_chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
		if (a == 7'h1d)
			exp_crc = 8'h00;
	endtask : wr
	task automatic convert(input logic [23:0] r, input logic [2:0] c, input logic [1:0] o, input logic nr);
		@(posedge clk);
		#1 res = r;
		ch = c;
		ovr = o;
		rail = nr;
		cdone = 1'b1;
		@(posedge clk);
		#1 cdone = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : convert
	task automatic t_power_up();
		chk("ready_n", 8'h01, {7'h00, ready_n});
		ce = 1'b0;
		convert(24'h000100, 3'h1, 2'h0, 1'b0);
		chk("ready_n", 8'h01, {7'h00, ready_n});
		ce = 1'b1;
		rd_chk(7'h18, 8'hff);
		rd_chk(7'h19, 8'h20, 8'h20);
		rd_chk(7'h19, 8'h00, 8'h20);
		rd_chk(7'h30, 8'h00);
		wr(7'h1d, 8'h5a);
		rd_chk(7'h1d, 8'h00);
		$display("test power_up done");
	endtask : t_power_up
	task automatic t_result();
		@(posedge clk);
		#1 scanp = 1'b1;
		convert(24'hffff80, 3'h5, 2'h2, 1'b1);
		rd_chk(7'h18, 8'h00);
		rd_chk(7'h19, 8'hd5);
		rd_chk(7'h1a, 8'hff);
		rd_chk(7'h1b, 8'hff);
		rd_chk(7'h1c, 8'h80);
		chk("ready_n", 8'h01, {7'h00, ready_n});
		exp_crc = 8'h00;
		rd_chk(7'h1e, 8'h02);
		rd_chk(7'h18, 8'hff);
		repeat (7300) @(posedge clk);
		rd_chk(7'h1a, 8'hff);
		rd_chk(7'h1e, 8'h03);
		@(posedge clk);
		#1 scanp = 1'b0;
		rd_chk(7'h1e, 8'h01);
		rd_chk(7'h1d, exp_crc);
		$display("test result done");
	endtask : t_result
	task automatic t_after_crc();
		@(posedge clk);
		#1 rel_crc = 1'b1;
		crc_off = 1'b1;
		wr(7'h14, 8'h00);
		wr(7'h15, 8'h10);
		rd_chk(7'h15, 8'h10);
		convert(24'h001234, 3'h2, 2'h1, 1'b0);
		rd_chk(7'h19, 8'h0a);
		rd_chk(7'h1a, 8'h00);
		repeat (7300) @(posedge clk);
		rd_chk(7'h1a, 8'h00);
		rd_chk(7'h1e, 8'h01);
		rd_chk(7'h1b, 8'h12);
		rd_chk(7'h1c, 8'h34);
		chk("ready_n", 8'h00, {7'h00, ready_n});
		rd_chk(7'h1d, exp_crc);
		chk("ready_n", 8'h01, {7'h00, ready_n});
		rd_chk(7'h1d, exp_crc);
		wr(7'h1d, 8'hc3);
		rd_chk(7'h1d, 8'h00);
		$display("test after_crc done");
	endtask : t_after_crc
	task automatic t_cal();
		wr(7'h17, 8'h03);
		rd_chk(7'h17, 8'h00);
		for (int i = 1; i <= 2; i++) begin
			wr(7'h17, 8'(i));
			chk("cal_mode", 8'(i), {6'h00, cal});
			rd_chk(7'h17, 8'(i));
			convert(24'hfff000, 3'(i), (i == 1) ? 2'h3 : 2'h0, 1'b0);
			chk("cal_mode", 8'h00, {6'h00, cal});
			rd_chk(7'h17, 8'h00);
			rd_chk(7'h19, (i == 1) ? 8'h99 : 8'h82);
		end
		$display("test cal done");
	endtask : t_cal
	initial begin
		{rst, ce, cdone, rail, scanp, rel_crc, crc_off} = 7'b1100000;
		res = 24'h000000;
		ch = 3'h0;
		ovr = 2'h0;
		exp_crc = 8'h00;
		n_mismatch = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		t_power_up();
		t_result();
		t_after_crc();
		t_cal();
		close_out();
	end
endmodule : arsr_regs_tb_top
`default_nettype wire
